// [supervisor_ctrl.sv]
/*
  supply supervisor, detector, display and clock control for a small mcu.
  assumes: slow_tick is a free-running slow clock from outside (synchronised
  here), supply pins are async, options are static straps.
*/
// The plain strobed port was chosen for this implementation.
`include "supervisor_cfg.svh"

module supervisor_ctrl
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire supervisor_pkg::options_s options,
  input wire logic halt_mode,
  input wire logic power_on_reset,
  input wire logic supply_low_raw,
  input wire logic detector_low_raw,
  input wire logic slow_tick_raw,
  input wire logic [7:0] prescaler_taps,
  output logic chip_reset,
  output logic startup_hold,
  output logic display_on,
  output logic clock_osc_on,
  output logic rtc_tick,
  output logic display_clk,
  output logic fast_osc_start,
  output supervisor_pkg::analog_en_s analog_en
);

  localparam logic [15:0] FILTER_TICKS = 16'(`FILTER_TICKS);
  localparam logic [15:0] DELAY_TICKS = 16'(`DELAY_TICKS);
  localparam logic [10:0] STARTUP_CYCLES = 11'(`STARTUP_CYCLES);

  // two-flop synchronisers; stage one is read only by stage two
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic supply_low;
  logic detector_low;
  logic slow_lvl;
  logic por_s;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else
    begin
      sync1_q <= {power_on_reset, slow_tick_raw, detector_low_raw, supply_low_raw};
      sync2_q <= sync1_q;
    end
  end

  assign supply_low = sync2_q[0];
  assign detector_low = sync2_q[1];
  assign slow_lvl = sync2_q[2];
  assign por_s = sync2_q[3];

  logic slow_prev_q;
  logic slow_edge;
  assign slow_edge = slow_lvl & ~slow_prev_q;

  // register state
  logic clock_en_q;
  logic clock_en_d;
  logic display_en_q;
  logic display_en_d;
  logic [2:0] tap_sel_q;
  logic [2:0] tap_sel_d;
  logic det_en_q;
  logic det_en_d;
  logic fast_start_q;
  logic fast_start_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  logic det_running;
  logic reset_cmp_active;
  assign det_running = options.detector_opt & det_en_q;
  assign reset_cmp_active = options.reset_opt & ~halt_mode;

  // unmapped addresses and unused bits read zero
  function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic flag);
    read_mux = 8'h00;
    if (addr == `OFS_DISPLAY_CLOCK_ENABLE_CTRL)
      read_mux = {6'h00, display_en_q, clock_en_q};
    else if (addr == `OFS_RTC_PRESCALE_DETECTOR_CTRL)
      read_mux = {2'h0, flag, fast_start_q, det_en_q, tap_sel_q};
  endfunction : read_mux

  logic flag_now;
  assign flag_now = det_running & detector_low;

  always_comb
  begin
    clock_en_d = clock_en_q;
    display_en_d = display_en_q;
    tap_sel_d = tap_sel_q;
    det_en_d = det_en_q;
    fast_start_d = fast_start_q;
    rdata_d = 8'h00;
    if (reg_wr && reg_addr == `OFS_DISPLAY_CLOCK_ENABLE_CTRL)
    begin
      clock_en_d = reg_wdata[`BIT_CLOCK_OSC_ON];
      display_en_d = reg_wdata[`BIT_DISPLAY_ON];
    end
    if (reg_wr && reg_addr == `OFS_RTC_PRESCALE_DETECTOR_CTRL)
    begin
      tap_sel_d = reg_wdata[2:0];
      det_en_d = reg_wdata[`BIT_DETECTOR_ENABLE];
      fast_start_d = reg_wdata[`BIT_FAST_OSC_START];
    end
    // read data stand for one cycle only, then fall back to zero
    if (reg_rd)
      rdata_d = read_mux(reg_addr, flag_now);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      clock_en_q <= 1'b0;
      display_en_q <= 1'b0;
      tap_sel_q <= 3'h0;
      det_en_q <= 1'b0;
      fast_start_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      clock_en_q <= clock_en_d;
      display_en_q <= display_en_d;
      tap_sel_q <= tap_sel_d;
      det_en_q <= det_en_d;
      fast_start_q <= fast_start_d;
      rdata_q <= rdata_d;
    end
  end

  // low-voltage reset sequencer, timed in slow ticks but clocked by ref_clk, so it stops when ref_clk stops
  // a dip that clears during the delay still ends in reset; only the filter restarts
  supervisor_pkg::supply_seq_e state_q;
  supervisor_pkg::supply_seq_e state_d;
  logic [15:0] tick_cnt_q;
  logic [15:0] tick_cnt_d;
  logic seq_reset_req;

  always_comb
  begin
    state_d = state_q;
    tick_cnt_d = tick_cnt_q;
    unique case (state_q)
      supervisor_pkg::ST_RUN:
      begin
        tick_cnt_d = 16'h0000;
        if (reset_cmp_active && supply_low)
          state_d = supervisor_pkg::ST_FILTER;
      end
      supervisor_pkg::ST_FILTER:
      begin
        if (!reset_cmp_active || !supply_low)
        begin
          state_d = supervisor_pkg::ST_RUN;
          tick_cnt_d = 16'h0000;
        end
        else if (slow_edge)
        begin
          // must exceed the filter time, so one tick past it
          if (tick_cnt_q == FILTER_TICKS)
          begin
            state_d = supervisor_pkg::ST_DELAY;
            tick_cnt_d = 16'h0000;
          end
          else
            tick_cnt_d = 16'(tick_cnt_q + 16'h0001);
        end
      end
      supervisor_pkg::ST_DELAY:
      begin
        if (slow_edge)
        begin
          if (tick_cnt_q == DELAY_TICKS - 16'h0001)
            state_d = supervisor_pkg::ST_RESET;
          else
            tick_cnt_d = 16'(tick_cnt_q + 16'h0001);
        end
      end
      supervisor_pkg::ST_RESET:
      begin
        tick_cnt_d = 16'h0000;
        if (!supply_low)
          state_d = supervisor_pkg::ST_RUN;
      end
    endcase
  end

  // the sequencer is not cleared by the chip reset it produces, only by reset
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_q <= supervisor_pkg::ST_RUN;
      tick_cnt_q <= 16'h0000;
      slow_prev_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tick_cnt_q <= tick_cnt_d;
      slow_prev_q <= slow_lvl;
    end
  end

  assign seq_reset_req = (state_q == supervisor_pkg::ST_RESET);

  // start-up stabilisation
  logic chip_rst_d;
  logic chip_rst_q;
  logic [10:0] stab_cnt_q;
  logic [10:0] stab_cnt_d;
  logic hold_d;
  logic hold_q;

  // counts ref_clk cycles as system clock pulses and stops at the end value
  always_comb
  begin
    chip_rst_d = seq_reset_req | por_s;
    stab_cnt_d = stab_cnt_q;
    if (chip_rst_d)
      stab_cnt_d = 11'h000;
    else if (stab_cnt_q != STARTUP_CYCLES)
      stab_cnt_d = 11'(stab_cnt_q + 11'h001);
    hold_d = chip_rst_d | (stab_cnt_d != STARTUP_CYCLES);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      chip_rst_q <= 1'b1;
      stab_cnt_q <= 11'h000;
      hold_q <= 1'b1;
    end
    else
    begin
      chip_rst_q <= chip_rst_d;
      stab_cnt_q <= stab_cnt_d;
      hold_q <= hold_d;
    end
  end

  // slow clock gating, display divider and tick select
  logic disp_d;
  logic clk_on_d;
  logic [7:0] div_cnt_q;
  logic [7:0] div_cnt_d;
  logic disp_clk_d;
  logic disp_clk_q;
  logic tick_d;
  logic tick_q;
  supervisor_pkg::analog_en_s an_d;
  supervisor_pkg::analog_en_s an_q;
  logic disp_q;
  logic clk_on_q;
  logic fast_q;
  logic fast_d;
  logic div_tap;
  logic clk_run_d;

  always_comb
  begin
    disp_d = 1'b0;
    clk_on_d = 1'b0;
    unique case (options.slow_src)
      supervisor_pkg::SRC_SYS_DIV4:
      begin
        disp_d = 1'b0;
        clk_on_d = 1'b0;
      end
      supervisor_pkg::SRC_RC_OSC:
      begin
        disp_d = display_en_q;
        clk_on_d = 1'b0;
      end
      supervisor_pkg::SRC_CRYSTAL:
      begin
        disp_d = display_en_q;
        clk_on_d = 1'b1;
      end
      default:
      begin
        disp_d = 1'b0;
        clk_on_d = 1'b0;
      end
    endcase
    div_cnt_d = slow_edge ? 8'(div_cnt_q + 8'h01) : div_cnt_q;
    // select 0 means 2^2; values past 6 clamp at 2^8
    if (options.display_div_sel > 3'h6)
      div_tap = div_cnt_q[7];
    else
      div_tap = div_cnt_q[options.display_div_sel + 3'h1];
    disp_clk_d = div_tap & disp_d;
    clk_run_d = clk_on_d & clock_en_q;
    // the pin is high for quick start, the register bit is its inverse
    fast_d = ~fast_start_q;
    tick_d = clk_on_d & prescaler_taps[tap_sel_q];
    // reference stays up for the reset comparator even while halted
    an_d.ref_gen_on = options.reset_opt | det_running;
    an_d.reset_cmp_on = reset_cmp_active;
    an_d.detector_cmp_on = det_running;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      div_cnt_q <= 8'h00;
      disp_clk_q <= 1'b0;
      tick_q <= 1'b0;
      an_q <= '0;
      disp_q <= 1'b0;
      clk_on_q <= 1'b0;
      fast_q <= 1'b1;
    end
    else
    begin
      div_cnt_q <= div_cnt_d;
      disp_clk_q <= disp_clk_d;
      tick_q <= tick_d;
      an_q <= an_d;
      disp_q <= disp_d;
      clk_on_q <= clk_run_d;
      fast_q <= fast_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign chip_reset = chip_rst_q;
  assign startup_hold = hold_q;
  assign display_on = disp_q;
  assign clock_osc_on = clk_on_q;
  assign rtc_tick = tick_q;
  assign display_clk = disp_clk_q;
  assign fast_osc_start = fast_q;
  assign analog_en = an_q;

endmodule : supervisor_ctrl

// [supervisor_cfg.svh]
/*
  constants for the supply supervisor and display/clock control block:
  register offsets, field positions, reset values and timing counts.
  assumes a 40 MHz ref_clk and a free-running slow clock tick input.
*/
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH

`define OFS_RTC_PRESCALE_DETECTOR_CTRL 8'h09
`define OFS_DISPLAY_CLOCK_ENABLE_CTRL 8'h1F

`define BIT_CLOCK_OSC_ON 0
`define BIT_DISPLAY_ON 1
`define BIT_DETECTOR_ENABLE 3
`define BIT_FAST_OSC_START 4
`define BIT_DETECTOR_FLAG 5

`define RST_DISPLAY_CLOCK_CTRL 2'h0
`define RST_RTC_CTRL 5'h00

`define REF_CLK_HZ 40000000
`define FILTER_TIME_US 1000
`define DELAY_TIME_US 1000
`define SLOW_CLK_HZ 32768
// 1 ms counted in slow ticks, longest time rounded down
`define FILTER_TICKS ((`FILTER_TIME_US * `SLOW_CLK_HZ) / 1000000)
`define DELAY_TICKS ((`DELAY_TIME_US * `SLOW_CLK_HZ) / 1000000)
`define STARTUP_CYCLES 1024

`endif

// [supervisor_pkg.sv]
/*
  types for the supply supervisor block.
  assumes supervisor_cfg.svh supplies the numeric constants.
*/
package supervisor_pkg;

  typedef enum logic [1:0]
  {
    SRC_SYS_DIV4 = 2'b00,
    SRC_CRYSTAL = 2'b01,
    SRC_RC_OSC = 2'b10
  } slow_src_e;

  typedef enum logic [1:0]
  {
    ST_RUN = 2'b00,
    ST_FILTER = 2'b01,
    ST_DELAY = 2'b10,
    ST_RESET = 2'b11
  } supply_seq_e;

  typedef struct packed
  {
    logic reset_opt;
    logic detector_opt;
    slow_src_e slow_src;
    logic [2:0] display_div_sel;
  } options_s;

  typedef struct packed
  {
    logic ref_gen_on;
    logic reset_cmp_on;
    logic detector_cmp_on;
  } analog_en_s;

endpackage : supervisor_pkg

// [supervisor_ctrl_assertions.sv]
/* port checker for supervisor_ctrl.
   assumes static options and registered outputs. */
module supervisor_ctrl_checker
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire supervisor_pkg::options_s options,
  input wire logic halt_mode,
  input wire logic power_on_reset,
  input wire logic chip_reset,
  input wire logic startup_hold,
  input wire logic display_on,
  input wire logic clock_osc_on,
  input wire logic rtc_tick,
  input wire logic display_clk,
  input wire supervisor_pkg::analog_en_s analog_en
);
  logic [10:0] low_q;
  logic [10:0] low_d;
  // saturates so a long quiet spell cannot wrap into the window
  always_comb
  begin
    low_d = low_q;
    if (chip_reset)
      low_d = 11'h000;
    else if (low_q != 11'h7FF)
      low_d = low_q + 11'h001;
  end
  always_ff @(posedge ref_clk) low_q <= reset ? 11'h000 : low_d;
  default clocking dflt_cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
  flag_gate_a: assert property (
    reg_rd && reg_addr == 8'h09 && !options.detector_opt |=> !reg_rdata[5])
    else $error("flag set with detector option off");
  src_off_a: assert property (
    options.slow_src == supervisor_pkg::SRC_SYS_DIV4 |-> !(display_on || clock_osc_on || rtc_tick))
    else $error("display or clock on with divided source");
  clk_src_a: assert property (
    clock_osc_on || rtc_tick |-> options.slow_src == supervisor_pkg::SRC_CRYSTAL)
    else $error("clock running without crystal source");
  lcd_clk_a: assert property (
    !display_on && !$past(display_on) |-> !display_clk) else $error("display clock while off");
  reset_cmp_a: assert property (
    !$past(reset) |-> analog_en.reset_cmp_on == (options.reset_opt && !$past(halt_mode)))
    else $error("reset comparator enable wrong");
  det_cmp_a: assert property (
    analog_en.detector_cmp_on |-> options.detector_opt && analog_en.ref_gen_on)
    else $error("detector comparator without reference");
  por_or_a: assert property (
    power_on_reset [*4] |-> ##1 chip_reset) else $error("power-on reset not passed");
  hold_len_a: assert property (
    $fell(startup_hold) |-> low_q >= 11'h3FC && low_q <= 11'h404)
    else $error("start-up hold length wrong");
endmodule : supervisor_ctrl_checker

bind supervisor_ctrl supervisor_ctrl_checker chk_u
(
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .options(options), .halt_mode(halt_mode),
  .power_on_reset(power_on_reset), .chip_reset(chip_reset), .startup_hold(startup_hold),
  .display_on(display_on), .clock_osc_on(clock_osc_on), .rtc_tick(rtc_tick),
  .display_clk(display_clk), .analog_en(analog_en)
);

// [supervisor_ctrl_tb.sv]
/* self-checking bench for supervisor_ctrl.
   assumes the bound checker; makes a slow tick of ref_clk/8. */
module supervisor_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic halt_mode = 1'b0;
  logic power_on_reset = 1'b0;
  logic supply_low_raw = 1'b0;
  logic detector_low_raw = 1'b0;
  logic slow_tick_raw = 1'b0;
  logic [7:0] prescaler_taps = 8'h00;
  supervisor_pkg::options_s options = '0;
  logic [7:0] reg_rdata;
  logic chip_reset, startup_hold, display_on, clock_osc_on;
  logic rtc_tick, display_clk, fast_osc_start;
  supervisor_pkg::analog_en_s analog_en;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  supervisor_ctrl dut_u
  (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .options(options),
    .halt_mode(halt_mode), .power_on_reset(power_on_reset),
    .supply_low_raw(supply_low_raw), .detector_low_raw(detector_low_raw),
    .slow_tick_raw(slow_tick_raw), .prescaler_taps(prescaler_taps),
    .chip_reset(chip_reset), .startup_hold(startup_hold), .display_on(display_on),
    .clock_osc_on(clock_osc_on), .rtc_tick(rtc_tick), .display_clk(display_clk),
    .fast_osc_start(fast_osc_start), .analog_en(analog_en)
  );
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // a fast slow tick keeps the filter and delay counts short in ref cycles
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    slow_tick_raw <= cyc[2];
    prescaler_taps <= cyc[7:0];
    if (cyc == 40000)
    begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic check(input logic [7:0] seen, input logic [7:0] e);
    n_checks++;
    if (seen !== e)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, e);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, e);
  endtask : rd
  task automatic restart(input logic ro, input logic dopt, input logic [1:0] src,
                         input logic [2:0] dsel = 3'h0);
    @(posedge ref_clk);
    reset <= 1'b1;
    options <= '{ro, dopt, supervisor_pkg::slow_src_e'(src), dsel};
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    tick(4);
  endtask : restart
  // counts rising edges of display_clk and rtc_tick
  task automatic watch(input int len, output int nd, output int nr);
    logic pd;
    logic pr;
    nd = 0;
    nr = 0;
    pd = display_clk;
    pr = rtc_tick;
    repeat (len)
    begin
      tick(1);
      if (display_clk === 1'b1 && pd === 1'b0)
        nd++;
      if (rtc_tick === 1'b1 && pr === 1'b0)
        nr++;
      pd = display_clk;
      pr = rtc_tick;
    end
  endtask : watch
  task automatic t_regs();
    restart(1'b1, 1'b1, 2'h1);
    rd(8'h1F, 8'h00);
    rd(8'h09, 8'h00);
    wr(8'h1F, 8'hFF);
    rd(8'h1F, 8'h03);
    wr(8'h09, 8'hFF);
    rd(8'h09, 8'h1F);
    check(fast_osc_start, 1'b0);
    wr(8'h09, 8'h20);
    rd(8'h09, 8'h00);
    check(fast_osc_start, 1'b1);
    rd(8'h40, 8'h00);
  endtask : t_regs
  task automatic t_sel();
    int nd;
    int nr;
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h09, 8'(k));
      tick(4);
      watch(256, nd, nr);
      check(8'(nr), 8'(128 >> k));
    end
  endtask : t_sel
  task automatic t_gate();
    int nd;
    int nr;
    for (int s = 0; s < 4; s++)
    begin
      restart(1'b1, 1'b0, 2'(s));
      for (int v = 0; v < 4; v++)
      begin
        wr(8'h1F, 8'(v));
        tick(3);
        watch(64, nd, nr);
        check(display_on, v[1] && (s == 1 || s == 2));
        check(clock_osc_on, v[0] && s == 1);
        check(nd != 0, v[1] && (s == 1 || s == 2));
        check(nr != 0, s == 1);
      end
    end
  endtask : t_gate
  task automatic t_det();
    restart(1'b0, 1'b1, 2'h1);
    wr(8'h09, 8'h08);
    detector_low_raw <= 1'b1;
    tick(4);
    rd(8'h09, 8'h28);
    check(analog_en, 3'h5);
    wr(8'h09, 8'h00);
    tick(2);
    check(analog_en, 3'h0);
    rd(8'h09, 8'h00);
    restart(1'b1, 1'b0, 2'h1);
    check(analog_en, 3'h6);
    wr(8'h09, 8'h08);
    rd(8'h09, 8'h08);
    check(analog_en, 3'h6);
    @(posedge ref_clk) halt_mode <= 1'b1;
    tick(2);
    check(analog_en.reset_cmp_on, 1'b0);
    @(posedge ref_clk) halt_mode <= 1'b0;
    detector_low_raw <= 1'b0;
  endtask : t_det
  task automatic t_lvr();
    int n;
    tick(1100);
    @(posedge ref_clk) supply_low_raw <= 1'b1;
    tick(200);
    @(posedge ref_clk) supply_low_raw <= 1'b0;
    tick(4);
    @(posedge ref_clk) supply_low_raw <= 1'b1;
    tick(200);
    @(posedge ref_clk) supply_low_raw <= 1'b0;
    tick(400);
    check(chip_reset, 1'b0);
    check(startup_hold, 1'b0);
    @(posedge ref_clk) halt_mode <= 1'b1;
    supply_low_raw <= 1'b1;
    tick(700);
    check(chip_reset, 1'b0);
    check(startup_hold, 1'b0);
    @(posedge ref_clk) supply_low_raw <= 1'b0;
    halt_mode <= 1'b0;
    tick(4);
    @(posedge ref_clk) supply_low_raw <= 1'b1;
    tick(470);
    check(chip_reset, 1'b0);
    for (n = 0; n < 100 && chip_reset !== 1'b1; n++)
      tick(1);
    check(chip_reset, 1'b1);
    @(posedge ref_clk) supply_low_raw <= 1'b0;
    for (n = 0; n < 1200 && startup_hold !== 1'b0; n++)
      tick(1);
    check(n > 1020 && n < 1040, 1'b1);
  endtask : t_lvr
  task automatic t_por();
    @(posedge ref_clk) power_on_reset <= 1'b1;
    tick(6);
    check(chip_reset, 1'b1);
    @(posedge ref_clk) power_on_reset <= 1'b0;
    tick(6);
    check(chip_reset, 1'b0);
  endtask : t_por
  task automatic t_div();
    int nd;
    int nr;
    for (int d = 0; d < 8; d++)
    begin
      restart(1'b1, 1'b0, 2'h1, 3'(d));
      wr(8'h1F, 8'h02);
      tick(3);
      watch(2048, nd, nr);
      check(8'(nd), 8'(2048 >> ((d > 6 ? 6 : d) + 5)));
    end
  endtask : t_div
  initial
  begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_sel();
    t_gate();
    t_det();
    t_lvr();
    t_por();
    t_div();
    summarize();
  end
endmodule : supervisor_ctrl_tb
